// file: include/lpm_pkg.sv
package lpm_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int EXT_LINES    = 16;
  localparam int EVT_LINES    = EXT_LINES + 3;
  localparam int CTRL_ADDR_W  = 4;
  localparam int DATA_W       = 32;

  // ************************************************************
  // register offsets (word index on the plain port)
  // ************************************************************
  localparam logic [CTRL_ADDR_W-1:0] OFS_CTRL     = 4'h0;
  localparam logic [CTRL_ADDR_W-1:0] OFS_WAKE_EN  = 4'h1;
  localparam logic [CTRL_ADDR_W-1:0] OFS_STATUS   = 4'h2;
  localparam logic [CTRL_ADDR_W-1:0] OFS_MON_FLAG = 4'h3;

  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int CTRL_MODE_LO   = 0;  // 2 bits: target mode
  localparam int CTRL_LPREG     = 2;  // stop mode uses low-power regulator
  localparam int CTRL_MON_EN    = 3;  // supply monitor enable
  localparam int CTRL_ENTER     = 4;  // write 1: request mode entry
  localparam int MON_FALL_BIT   = 0;
  localparam int MON_RISE_BIT   = 1;

  localparam logic [1:0] TGT_SLEEP   = 2'h0;
  localparam logic [1:0] TGT_STOP    = 2'h1;
  localparam logic [1:0] TGT_STANDBY = 2'h2;

  localparam logic [EVT_LINES-1:0] WAKE_EN_RST = {EVT_LINES{1'b0}};

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ         = 250;
  localparam int RESTART_NS      = 100;
  localparam int RESTART_CYC     = (RESTART_NS * CLK_MHZ + 999) / 1000;
  localparam int RESTART_W       = $clog2(RESTART_CYC + 1);

  // ************************************************************
  // states and carriers
  // ************************************************************
  typedef enum logic [4:0] {
    ST_RUN     = 5'h01,
    ST_SLEEP   = 5'h02,
    ST_STOP    = 5'h04,
    ST_STANDBY = 5'h08,
    ST_RESTART = 5'h10
  } pm_state_t;

  typedef struct packed {
    logic cpuClkEn;
    logic pllEn;
    logic intHsRcOscEn;
    logic extHsCrystalOscEn;
    logic regulatorEn;
    logic lowPowerRegulatorMode;
    logic coreRetain;
    logic lowSpeedDomainEn;
  } power_ctl_t;

  typedef struct packed {
    logic extResetPin;
    logic indepWatchdogReset;
    logic wakeupPin;
    logic rtcAlarm;
  } standby_src_t;

endpackage : lpm_pkg

// file: verilog/sync_two_ff.sv
`timescale 1ns/10ps
module sync_two_ff #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  always_comb begin
    state_nxt.meta = din;
    state_nxt.sync = state_r.meta;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign dout = state_r.sync;

endmodule : sync_two_ff

// file: verilog/low_power_mode_sequencer.sv
// Function
// - sleep stops only the processor clock
// - any enabled interrupt or event ends sleep
// - stop turns off PLL and fast oscillators
// - stop keeps main or low-power regulator per setting
// - stop retains SRAM and register contents
// - enabled event controller line ends stop
// - stop wakes: 16 lines, monitor, RTC, USB
// - standby turns off regulator, PLL, oscillators
// - standby loses core state, keeps backup domain
// - standby exits: reset pin, watchdog, wakeup edge, alarm
// - RTC, watchdog and their clocks keep running
// - regulator on after reset, off in standby
// - low supply holds whole system in reset
// - monitor interrupts on falling or rising crossing
// - backup domain survives resets and standby wake
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
module low_power_mode_sequencer #(
  parameter int RESTART_CYCLES = lpm_pkg::RESTART_CYC
) (
  input  wire logic                              mclk,
  input  wire logic                              rstn,
  // register port
  input  wire logic [lpm_pkg::CTRL_ADDR_W-1:0]   regAddr,
  input  wire logic [lpm_pkg::DATA_W-1:0]        regWdata,
  input  wire logic                              regWr,
  input  wire logic                              regRd,
  output logic      [lpm_pkg::DATA_W-1:0]        regRdata,
  // wake and interrupt sources
  input  wire logic                              irqPending,
  input  wire logic [lpm_pkg::EXT_LINES-1:0]     extLineEvt,
  input  wire logic                              rtcAlarm,
  input  wire logic                              usbDeviceWake,
  input  wire lpm_pkg::standby_src_t             standbySrc,
  // supply comparators (analog, asynchronous)
  input  wire logic                              supplyBelowResetThreshold,
  input  wire logic                              supplyBelowMonitorThreshold,
  // outputs
  output lpm_pkg::power_ctl_t                    powerCtl,
  output logic                                   systemResetN,
  output logic                                   monitorIrq,
  output logic                                   supplyVoltageMonitorOut,
  output lpm_pkg::pm_state_t                     pmState
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  localparam int NSYNC  = lpm_pkg::EXT_LINES + 8;
  localparam int DATA_W = lpm_pkg::DATA_W;
  localparam int CNT_W  = $clog2(RESTART_CYCLES + 1);

  logic [NSYNC-1:0] asyncIn;
  logic [NSYNC-1:0] syncIn;

  // pins and comparators are async; logic reads only the second flop
  assign asyncIn = {extLineEvt,
                    rtcAlarm,
                    usbDeviceWake,
                    standbySrc.extResetPin,
                    standbySrc.indepWatchdogReset,
                    standbySrc.wakeupPin,
                    standbySrc.rtcAlarm,
                    supplyBelowResetThreshold,
                    supplyBelowMonitorThreshold};

  sync_two_ff #(.W(NSYNC)) inSync (
    .mclk (mclk),
    .rstn (rstn),
    .din  (asyncIn),
    .dout (syncIn)
  );

  logic [lpm_pkg::EXT_LINES-1:0] extLineS;
  logic                          rtcAlarmS;
  logic                          usbWakeS;
  logic                          extResetPinS;
  logic                          watchdogRstS;
  logic                          wakeupPinS;
  logic                          sbyAlarmS;
  logic                          lowSupplyS;
  logic                          belowMonS;

  assign {extLineS,
          rtcAlarmS,
          usbWakeS,
          extResetPinS,
          watchdogRstS,
          wakeupPinS,
          sbyAlarmS,
          lowSupplyS,
          belowMonS} = syncIn;

  // ************************************************************
  // state
  // ************************************************************
  // local alias keeps the struct field self-contained
  typedef lpm_pkg::power_ctl_t power_ctl_local_t;

  typedef struct packed {
    lpm_pkg::pm_state_t                 mode;
    logic [1:0]                         target;
    logic                               lpReg;
    logic                               monEn;
    logic [lpm_pkg::EVT_LINES-1:0]      wakeEn;
    logic [1:0]                         monFlag;
    logic                               monPrev;
    logic                               monValid;
    logic                               wakePinPrev;
    logic [CNT_W-1:0]                   restartCnt;
    logic                               sysRstN;
    logic [lpm_pkg::DATA_W-1:0]         rdata;
    power_ctl_local_t                   pc;
  } seq_state_t;

  seq_state_t state_r;
  seq_state_t state_nxt;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic lpm_pkg::power_ctl_t ctl_for(input lpm_pkg::pm_state_t m, input logic lp);
    lpm_pkg::power_ctl_t c;
    c                       = '0;
    c.lowSpeedDomainEn      = 1'b1;
    c.regulatorEn           = 1'b1;
    c.coreRetain            = 1'b1;
    c.cpuClkEn              = 1'b1;
    c.pllEn                 = 1'b1;
    c.intHsRcOscEn          = 1'b1;
    c.extHsCrystalOscEn     = 1'b1;
    unique case (m)
      lpm_pkg::ST_RUN, lpm_pkg::ST_RESTART: begin
      end
      lpm_pkg::ST_SLEEP: begin
        c.cpuClkEn = 1'b0;
      end
      lpm_pkg::ST_STOP: begin
        c.cpuClkEn              = 1'b0;
        c.pllEn                 = 1'b0;
        c.intHsRcOscEn          = 1'b0;
        c.extHsCrystalOscEn     = 1'b0;
        c.lowPowerRegulatorMode = lp;
        c.coreRetain            = 1'b1;
      end
      lpm_pkg::ST_STANDBY: begin
        c.cpuClkEn          = 1'b0;
        c.pllEn             = 1'b0;
        c.intHsRcOscEn      = 1'b0;
        c.extHsCrystalOscEn = 1'b0;
        c.regulatorEn       = 1'b0;
        c.coreRetain        = 1'b0;
      end
      default: begin
      end
    endcase
    return c;
  endfunction : ctl_for

  logic [lpm_pkg::EVT_LINES-1:0] stopEvt;
  logic                          stopWake;
  logic                          sleepWake;
  logic                          standbyWake;
  logic                          wakePinRise;
  logic                          ctrlWr;
  logic                          wakeEnWr;
  logic                          monFlagWr;

  assign stopEvt     = {extLineS,
                        state_r.monFlag != 2'h0,
                        rtcAlarmS,
                        usbWakeS};
  assign stopWake    = |(stopEvt & state_r.wakeEn);
  // peripherals keep running in sleep, so their events end it too
  assign sleepWake   = irqPending | stopWake;

  // pin history resets low like the idle pin: no false edge
  assign wakePinRise = wakeupPinS & ~state_r.wakePinPrev;
  assign standbyWake = extResetPinS
                     | watchdogRstS
                     | wakePinRise
                     | sbyAlarmS;

  assign ctrlWr      = regWr && (regAddr == lpm_pkg::OFS_CTRL);
  assign wakeEnWr    = regWr && (regAddr == lpm_pkg::OFS_WAKE_EN);
  assign monFlagWr   = regWr && (regAddr == lpm_pkg::OFS_MON_FLAG);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_nxt             = state_r;
    state_nxt.wakePinPrev = wakeupPinS;

    // register writes; target and regulator chosen before entry
    if (ctrlWr) begin
      state_nxt.target = regWdata[lpm_pkg::CTRL_MODE_LO +: 2];
      state_nxt.lpReg  = regWdata[lpm_pkg::CTRL_LPREG];
      state_nxt.monEn  = regWdata[lpm_pkg::CTRL_MON_EN];
    end
    if (wakeEnWr) begin
      state_nxt.wakeEn = regWdata[lpm_pkg::EVT_LINES-1:0];
    end
    // write one to clear; a fresh crossing below still wins
    if (monFlagWr) begin
      state_nxt.monFlag = state_r.monFlag & ~regWdata[1:0];
    end

    // supply monitor, silent until enabled
    state_nxt.monPrev  = belowMonS;
    state_nxt.monValid = state_r.monEn;
    if (state_r.monEn && state_r.monValid) begin
      if (belowMonS && !state_r.monPrev) begin
        state_nxt.monFlag[lpm_pkg::MON_FALL_BIT] = 1'b1;
      end
      if (!belowMonS && state_r.monPrev) begin
        state_nxt.monFlag[lpm_pkg::MON_RISE_BIT] = 1'b1;
      end
    end

    unique case (state_r.mode)
      lpm_pkg::ST_RUN: begin
        if (ctrlWr && regWdata[lpm_pkg::CTRL_ENTER]) begin
          unique case (regWdata[lpm_pkg::CTRL_MODE_LO +: 2])
            lpm_pkg::TGT_STOP: begin
              state_nxt.mode = lpm_pkg::ST_STOP;
            end
            lpm_pkg::TGT_STANDBY: begin
              state_nxt.mode = lpm_pkg::ST_STANDBY;
            end
            default: begin
              state_nxt.mode = lpm_pkg::ST_SLEEP;
            end
          endcase
        end
      end
      lpm_pkg::ST_SLEEP: begin
        if (sleepWake) begin
          state_nxt.mode = lpm_pkg::ST_RUN;
        end
      end
      lpm_pkg::ST_STOP: begin
        if (stopWake) begin
          state_nxt.mode = lpm_pkg::ST_RUN;
        end
      end
      lpm_pkg::ST_STANDBY: begin
        if (standbyWake) begin
          state_nxt.mode       = lpm_pkg::ST_RESTART;
          state_nxt.restartCnt = '0;
        end
      end
      lpm_pkg::ST_RESTART: begin
        if (32'(state_r.restartCnt) >= RESTART_CYCLES - 1) begin
          state_nxt.mode = lpm_pkg::ST_RUN;
        end else begin
          state_nxt.restartCnt = state_r.restartCnt + 1'b1;
        end
      end
      default: begin
        state_nxt.mode = lpm_pkg::ST_RUN;
      end
    endcase

    // supply below threshold overrides everything; the count restarts
    // each low cycle, so reset outlasts the dip by a full restart
    if (lowSupplyS) begin
      state_nxt.mode       = lpm_pkg::ST_RESTART;
      state_nxt.restartCnt = '0;
    end

    // core registers are lost in standby and any restart, power reset too;
    // the backup domain is outside this block
    if (state_nxt.mode == lpm_pkg::ST_STANDBY || state_nxt.mode == lpm_pkg::ST_RESTART) begin
      state_nxt.target  = lpm_pkg::TGT_SLEEP;
      state_nxt.lpReg   = 1'b0;
      state_nxt.monEn   = 1'b0;
      state_nxt.wakeEn  = lpm_pkg::WAKE_EN_RST;
      state_nxt.monFlag = 2'h0;
    end

    state_nxt.sysRstN = (state_nxt.mode != lpm_pkg::ST_RESTART) &&
                        (state_nxt.mode != lpm_pkg::ST_STANDBY);
    state_nxt.pc      = ctl_for(state_nxt.mode, state_nxt.lpReg);

    state_nxt.rdata = '0;
    if (regRd) begin
      unique case (regAddr)
        lpm_pkg::OFS_CTRL: begin
          state_nxt.rdata = DATA_W'({state_r.monEn, state_r.lpReg, state_r.target});
        end
        lpm_pkg::OFS_WAKE_EN: begin
          state_nxt.rdata = DATA_W'(state_r.wakeEn);
        end
        lpm_pkg::OFS_STATUS: begin
          state_nxt.rdata = DATA_W'({belowMonS, state_r.mode});
        end
        lpm_pkg::OFS_MON_FLAG: begin
          state_nxt.rdata = DATA_W'(state_r.monFlag);
        end
        default: begin
          state_nxt.rdata = '0;
        end
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r            <= '0;
      state_r.mode       <= lpm_pkg::ST_RESTART;
      state_r.sysRstN    <= 1'b0;
      state_r.wakeEn     <= lpm_pkg::WAKE_EN_RST;
      state_r.pc         <= '{cpuClkEn:              1'b1,
                              pllEn:                 1'b1,
                              intHsRcOscEn:          1'b1,
                              extHsCrystalOscEn:     1'b1,
                              regulatorEn:           1'b1,
                              lowPowerRegulatorMode: 1'b0,
                              coreRetain:            1'b1,
                              lowSpeedDomainEn:      1'b1};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign powerCtl                = state_r.pc;
  assign systemResetN            = state_r.sysRstN;
  // monitor pin mirrors the interrupt until software clears the flags
  assign monitorIrq              = |state_r.monFlag;
  assign supplyVoltageMonitorOut = |state_r.monFlag;
  assign pmState                 = state_r.mode;
  assign regRdata                = state_r.rdata;

endmodule : low_power_mode_sequencer

// file: testbench/low_power_mode_sequencer_props.sv
`timescale 1ns/10ps
module lpm_seq_props #(
  parameter int RESTART_CYCLES = lpm_pkg::RESTART_CYC
) (
  input wire logic                          mclk,
  input wire logic                          rstn,
  input wire logic [lpm_pkg::CTRL_ADDR_W-1:0] regAddr,
  input wire logic [lpm_pkg::DATA_W-1:0]    regWdata,
  input wire logic                          regWr,
  input wire logic                          regRd,
  input wire logic [lpm_pkg::DATA_W-1:0]    regRdata,
  input wire logic                          irqPending,
  input wire lpm_pkg::standby_src_t         standbySrc,
  input wire logic                          supplyBelowResetThreshold,
  input wire lpm_pkg::power_ctl_t           powerCtl,
  input wire logic                          systemResetN,
  input wire logic                          monitorIrq,
  input wire logic                          supplyVoltageMonitorOut,
  input wire lpm_pkg::pm_state_t            pmState
);
  // ********
  // helpers
  // ********
  int restartCnt_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // raw supply input restarts the tally, so the window allows for sync delay
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) restartCnt_r <= 0;
    else if (supplyBelowResetThreshold || pmState != lpm_pkg::ST_RESTART) restartCnt_r <= 0;
    else restartCnt_r <= restartCnt_r + 1;
  end
  sequence s_enter(m);
    regWr && regAddr == lpm_pkg::OFS_CTRL && regWdata[lpm_pkg::CTRL_ENTER] && regWdata[1:0] == m
      && pmState == lpm_pkg::ST_RUN;
  endsequence
  // ********
  // properties
  // ********
  a_sleep_entry: assert property (s_enter(lpm_pkg::TGT_SLEEP) |=> pmState == lpm_pkg::ST_SLEEP)
    else $error("sleep not entered");
  a_sleep_cpu_only: assert property (pmState == lpm_pkg::ST_SLEEP |-> !powerCtl.cpuClkEn && powerCtl.pllEn
    && powerCtl.intHsRcOscEn && powerCtl.extHsCrystalOscEn && powerCtl.regulatorEn) else $error("sleep gating");
  a_sleep_wake: assert property (pmState == lpm_pkg::ST_SLEEP && irqPending |-> ##[1:4] pmState == lpm_pkg::ST_RUN)
    else $error("sleep kept despite interrupt");
  a_stop_clocks_off: assert property (pmState == lpm_pkg::ST_STOP |-> !powerCtl.pllEn && !powerCtl.intHsRcOscEn
    && !powerCtl.extHsCrystalOscEn && !powerCtl.cpuClkEn && powerCtl.regulatorEn && powerCtl.coreRetain)
    else $error("stop gating");
  a_stop_reg_mode: assert property (s_enter(lpm_pkg::TGT_STOP) |=> pmState == lpm_pkg::ST_STOP
    && powerCtl.lowPowerRegulatorMode == $past(regWdata[lpm_pkg::CTRL_LPREG])) else $error("stop regulator mode");
  a_standby_off: assert property (pmState == lpm_pkg::ST_STANDBY |-> !powerCtl.regulatorEn && !powerCtl.pllEn
    && !powerCtl.intHsRcOscEn && !powerCtl.extHsCrystalOscEn) else $error("standby power left on");
  a_low_speed_on: assert property (powerCtl.lowSpeedDomainEn)
    else $error("low speed domain stopped");
  a_standby_exit: assert property (pmState == lpm_pkg::ST_STANDBY && standbySrc.extResetPin
    |-> ##[1:3] pmState == lpm_pkg::ST_RESTART) else $error("standby kept despite reset pin");
  a_low_supply_reset: assert property (supplyBelowResetThreshold [*5] |-> pmState == lpm_pkg::ST_RESTART
    && !systemResetN) else $error("low supply not holding reset");
  a_restart_length: assert property (pmState == lpm_pkg::ST_RUN && $past(pmState) == lpm_pkg::ST_RESTART
    |-> restartCnt_r inside {[RESTART_CYCLES-1:RESTART_CYCLES+3]}) else $error("restart length off");
  a_reset_follows: assert property (systemResetN == (pmState inside {lpm_pkg::ST_RUN, lpm_pkg::ST_SLEEP,
    lpm_pkg::ST_STOP})) else $error("system reset mismatch");
  a_monitor_out: assert property (monitorIrq == supplyVoltageMonitorOut)
    else $error("monitor outputs differ");
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == '0)
    else $error("read data outside read cycle");
endmodule : lpm_seq_props
bind low_power_mode_sequencer lpm_seq_props #(.RESTART_CYCLES(RESTART_CYCLES)) i_props (.mclk, .rstn, .regAddr,
  .regWdata, .regWr, .regRd, .regRdata, .irqPending, .standbySrc, .supplyBelowResetThreshold, .powerCtl,
  .systemResetN, .monitorIrq, .supplyVoltageMonitorOut, .pmState);

// file: testbench/lpm_wake_peer.sv
`timescale 1ns/10ps
module lpm_wake_peer (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              fireReq,
  input  wire logic [4:0]        srcSel,
  input  wire logic [2:0]        delayCyc,
  output logic                   irqPending,
  output logic [15:0]            extLineEvt,
  output logic                   rtcAlarm,
  output logic                   usbDeviceWake,
  output lpm_pkg::standby_src_t  standbySrc
);
  // ********
  // one pulse at a time, after a chosen wait
  // ********
  logic [4:0]  sel_r;
  logic [2:0]  waitCnt_r;
  logic [3:0]  holdCnt_r;
  logic [22:0] act;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sel_r     <= 5'h00;
      waitCnt_r <= 3'h0;
      holdCnt_r <= 4'h0;
    end else if (fireReq) begin
      sel_r     <= srcSel;
      waitCnt_r <= delayCyc;
      holdCnt_r <= 4'h6;
    end else if (waitCnt_r != 3'h0) waitCnt_r <= waitCnt_r - 3'h1;
    else if (holdCnt_r != 4'h0) holdCnt_r <= holdCnt_r - 4'h1;
  end
  // held six cycles so the synchronisers see it; released lines fall to low
  assign act           = (waitCnt_r == 3'h0 && holdCnt_r != 4'h0) ? (23'h1 << sel_r) : 23'h0;
  assign extLineEvt    = act[15:0];
  assign rtcAlarm      = act[16];
  assign usbDeviceWake = act[17];
  assign irqPending    = act[18];
  assign standbySrc    = {act[19], act[20], act[21], act[22]};
endmodule : lpm_wake_peer

// file: testbench/low_power_mode_sequencer_bench.sv
`timescale 1ns/10ps
module low_power_mode_sequencer_bench;
  // ********
  // signals
  // ********
  logic mclk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, fireReq = 1'b0;
  logic belowRst = 1'b0, belowMon = 1'b0, irqPending, rtcAlarm, usbWake, sysRstN, monIrq;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata, d;
  logic [4:0] srcSel = 5'h00;
  logic [2:0] delayCyc = 3'h0;
  logic [15:0] extLineEvt;
  lpm_pkg::standby_src_t standbySrc;
  lpm_pkg::power_ctl_t powerCtl;
  lpm_pkg::pm_state_t pmState;
  int errCount = 0, comparisons = 0, src, lp;
  always #2 mclk = ~mclk;
  low_power_mode_sequencer #(.RESTART_CYCLES(2)) i_dut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqPending(irqPending),
    .extLineEvt(extLineEvt), .rtcAlarm(rtcAlarm), .usbDeviceWake(usbWake), .standbySrc(standbySrc),
    .supplyBelowResetThreshold(belowRst), .supplyBelowMonitorThreshold(belowMon), .powerCtl(powerCtl),
    .systemResetN(sysRstN), .monitorIrq(monIrq), .supplyVoltageMonitorOut(), .pmState(pmState));
  lpm_wake_peer i_peer (.mclk(mclk), .rstn(rstn), .fireReq(fireReq), .srcSel(srcSel), .delayCyc(delayCyc),
    .irqPending(irqPending), .extLineEvt(extLineEvt), .rtcAlarm(rtcAlarm), .usbDeviceWake(usbWake),
    .standbySrc(standbySrc));
  // ********
  // helpers
  // ********
  function automatic logic [5:0] exp_pwr(input lpm_pkg::pm_state_t st);
    case (st)
      lpm_pkg::ST_SLEEP:   return 6'h1F;
      lpm_pkg::ST_STOP:    return 6'h03;
      lpm_pkg::ST_STANDBY: return 6'h01;
      default:             return 6'h3F;
    endcase
  endfunction : exp_pwr
  function automatic logic [31:0] ctl(input logic [1:0] m, input int l, input int mon, input int en);
    return {27'h0, en[0], mon[0], l[0], m};
  endfunction : ctl
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_pwr(input lpm_pkg::pm_state_t st);
    chk(32'({powerCtl.cpuClkEn, powerCtl.pllEn, powerCtl.intHsRcOscEn, powerCtl.extHsCrystalOscEn,
      powerCtl.regulatorEn, powerCtl.lowSpeedDomainEn}), 32'(exp_pwr(st)));
  endtask : chk_pwr
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    regWr <= 1'b1; regAddr <= a; regWdata <= v;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rd
  task automatic fire(input int s, input int dl);
    @(posedge mclk);
    fireReq <= 1'b1; srcSel <= 5'(s); delayCyc <= 3'(dl);
    @(posedge mclk);
    fireReq <= 1'b0;
  endtask : fire
  task automatic wait_st(input lpm_pkg::pm_state_t st, input int lim);
    int n;
    n = 0;
    while (pmState !== st && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(32'(pmState), 32'(st));
    if (pmState !== st) wrap_up();
  endtask : wait_st
  // ********
  // sequence
  // ********
  initial begin
    src = $urandom(2959);
    repeat (5) @(posedge mclk);
    #1 chk(32'(pmState), 32'(lpm_pkg::ST_RESTART));
    chk_pwr(lpm_pkg::ST_RUN);
    @(posedge mclk) rstn <= 1'b1;
    wait_st(lpm_pkg::ST_RUN, 40);
    chk(32'(sysRstN), 32'h1);
    rd(lpm_pkg::OFS_WAKE_EN, d);
    chk(d, 32'(lpm_pkg::WAKE_EN_RST));
    rd(4'hF, d);
    chk(d, 32'h0);
    $display("test reset done");
    wr(lpm_pkg::OFS_CTRL, ctl(lpm_pkg::TGT_SLEEP, 0, 0, 1));
    #1 chk_pwr(lpm_pkg::ST_SLEEP);
    fire(18, 3);
    wait_st(lpm_pkg::ST_RUN, 20);
    repeat (8) @(posedge mclk);
    $display("test sleep done");
    for (int i = 0; i < 6; i++) begin
      src = (i < 4) ? $urandom_range(15, 0) : 12 + i;
      lp = $urandom_range(1, 0);
      wr(lpm_pkg::OFS_WAKE_EN, 32'h1 << ((src < 16) ? src + 3 : 17 - src));
      wr(lpm_pkg::OFS_CTRL, ctl(lpm_pkg::TGT_STOP, lp, 0, 1));
      #1 chk_pwr(lpm_pkg::ST_STOP);
      chk(32'(powerCtl.lowPowerRegulatorMode), 32'(lp));
      if (i == 0) begin
        fire((src + 1) % 16, 0);
        repeat (12) @(posedge mclk);
        #1 chk(32'(pmState), 32'(lpm_pkg::ST_STOP));
      end
      fire(src, $urandom_range(7, 0));
      wait_st(lpm_pkg::ST_RUN, 30);
      rd(lpm_pkg::OFS_WAKE_EN, d);
      chk(d, 32'h1 << ((src < 16) ? src + 3 : 17 - src));
      repeat (8) @(posedge mclk);
    end
    $display("test stop done");
    belowMon <= 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk(32'(monIrq), 32'h0);
    @(posedge mclk) belowMon <= 1'b0;
    wr(lpm_pkg::OFS_CTRL, ctl(lpm_pkg::TGT_SLEEP, 0, 1, 0));
    repeat (8) @(posedge mclk);
    belowMon <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(lpm_pkg::OFS_MON_FLAG, d);
    chk(d, 32'h1);
    rd(lpm_pkg::OFS_STATUS, d);
    chk(d, 32'h21);
    @(posedge mclk) belowMon <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(lpm_pkg::OFS_MON_FLAG, d);
    chk(d, 32'h3);
    wr(lpm_pkg::OFS_MON_FLAG, 32'h3);
    wr(lpm_pkg::OFS_CTRL, ctl(lpm_pkg::TGT_SLEEP, 0, 0, 0));
    #1 chk(32'(monIrq), 32'h0);
    $display("test monitor done");
    for (int j = 0; j < 4; j++) begin
      wr(lpm_pkg::OFS_WAKE_EN, 32'h7FFFF);
      wr(lpm_pkg::OFS_CTRL, ctl(lpm_pkg::TGT_STANDBY, 0, 0, 1));
      #1 chk_pwr(lpm_pkg::ST_STANDBY);
      chk(32'(sysRstN), 32'h0);
      if (j == 0) begin
        fire(3, 0);
        repeat (12) @(posedge mclk);
        #1 chk(32'(pmState), 32'(lpm_pkg::ST_STANDBY));
      end
      fire(19 + j, 2);
      wait_st(lpm_pkg::ST_RESTART, 20);
      wait_st(lpm_pkg::ST_RUN, 40);
      rd(lpm_pkg::OFS_WAKE_EN, d);
      chk(d, 32'(lpm_pkg::WAKE_EN_RST));
      repeat (8) @(posedge mclk);
    end
    $display("test standby done");
    belowRst <= 1'b1;
    repeat (10) @(posedge mclk);
    #1 chk(32'(pmState), 32'(lpm_pkg::ST_RESTART));
    chk(32'(sysRstN), 32'h0);
    @(posedge mclk) belowRst <= 1'b0;
    wait_st(lpm_pkg::ST_RUN, 40);
    $display("test supply done");
    wrap_up();
  end
endmodule : low_power_mode_sequencer_bench
